// ===== hbp_pkg.sv
package hbp_pkg;

    // ****************************************************
    // Bus widths
    // ****************************************************
    localparam int ADDR_W = 6;            // Register address lines
    localparam int DATA_W = 8;            // Data / shared lines

    // ****************************************************
    // Buffer sizing
    // ****************************************************
    localparam int FIFO_DEPTH = 64;       // Bytes per direction
    localparam int TX_FRAMES_MAX = 2;     // Frames held for transmit
    localparam int RX_FRAMES_MAX = 8;     // Frames held from receive
    localparam int FRAME_CNT_W = 4;       // Wide enough for 8

    // ****************************************************
    // Port-local addresses, served here before the core
    // ****************************************************
    localparam logic [5:0] TX_DATA_ADDR = 6'h3c;  // Push byte
    localparam logic [5:0] TX_EOF_ADDR = 6'h3d;   // Push last byte
    localparam logic [5:0] RX_DATA_ADDR = 6'h3e;  // Pop byte
    localparam logic [5:0] STATUS_ADDR = 6'h3f;   // FIFO flags

    // Status byte field positions
    localparam int ST_TX_FULL = 0;
    localparam int ST_RX_EMPTY = 1;
    localparam int ST_RX_LAST = 2;

    // ****************************************************
    // Types
    // ****************************************************
    // Byte plus end-of-frame marker
    typedef struct packed {
        logic last;
        logic [7:0] data;
    } hbp_entry_s;

    // Sampled bus controls, one cycle's view
    typedef struct packed {
        logic cs_n;           // Device select, active low
        logic pin27;          // Read/write or write strobe
        logic pin26;          // Enable, transfer strobe or read
        logic pin3;           // Address latch strobe
    } hbp_ctl_s;

    // Bus style in force
    typedef enum logic [1:0] {
        HBP_DEMUX,
        HBP_MUX_SPLIT,
        HBP_MUX_XSTB
    } hbp_style_e;

endpackage

// ===== hbp_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module hbp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 64
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    // ****************************************************
    // Elaboration checks
    // ****************************************************
    // Pointers wrap by power of two only
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("hbp_fifo DEPTH must be a power of two >= 2");
    end

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];      // Entry storage
    logic [AW-1:0] wp_r, wp_nxt;          // Write index
    logic [AW-1:0] rp_r, rp_nxt;          // Read index
    logic [AW:0] cnt_r, cnt_nxt;          // Fill level
    logic push, pop;

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and level next state
    always_comb begin
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Registers; storage needs no reset
    always_ff @(posedge clock) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

endmodule

`default_nettype wire

// ===== hbp_port.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Strap high: multiplexed bus plus DMA; low: separated
// - Separated: six address bits, read when high
// - Separated: enable falling edge ends access
// - Split strobes: address caught on latch fall
// - Strobe style: address fall, transfer-strobe fall ends
// - CPU accesses respond only while select is low; DMA needs no select
// - Open-drain interrupt request when service needed
// - Multiplexed: request per direction per byte
// - 64-byte FIFOs, two/eight frames held
// - Multiplexed: address and data share eight lines
module hbp_port (
    input wire logic clock,
    input wire logic resetn,
    input wire logic bus_mux_select,
    input wire logic split_strobes,
    input wire logic cs_n,
    input wire logic [5:0] addr_lines,
    input wire logic [7:0] data_lines_in,
    output logic [7:0] data_lines_out,
    output logic data_lines_oe,
    input wire logic pin27,
    input wire logic pin26,
    input wire logic addr_hold_strobe,
    output logic int_out,
    output logic int_oe,
    output logic dma_req_tx,
    input wire logic dma_ack_tx,
    output logic dma_req_rx,
    input wire logic dma_ack_rx,
    input wire logic core_irq,
    output logic [5:0] core_addr,
    output logic [7:0] core_wdata,
    output logic core_wr,
    output logic core_rd,
    input wire logic [7:0] core_rdata,
    output logic tx_valid,
    input wire logic tx_ready,
    output hbp_pkg::hbp_entry_s tx_data,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire hbp_pkg::hbp_entry_s rx_data
);

    // ****************************************************
    // Sampled pins and bus style
    // ****************************************************
    hbp_pkg::hbp_ctl_s ctl, ctl_r;        // Current and previous
    logic [7:0] din_r;                    // Lines one cycle back
    hbp_pkg::hbp_style_e style;

    assign ctl = '{cs_n: cs_n, pin27: pin27, pin26: pin26,
                   pin3: addr_hold_strobe};

    // Style from the two straps
    always_comb begin
        if (!bus_mux_select) begin
            style = hbp_pkg::HBP_DEMUX;
        end else if (split_strobes) begin
            style = hbp_pkg::HBP_MUX_SPLIT;
        end else begin
            style = hbp_pkg::HBP_MUX_XSTB;
        end
    end

    // ****************************************************
    // Access decode
    // ****************************************************
    logic rd_active;        // Read phase in progress
    logic end_wr, end_rd;   // Access completes this cycle
    logic latch_addr;       // Address strobe falling
    logic dma_cycle;        // Acknowledged DMA transfer

    always_comb begin
        rd_active = 1'b0;
        end_wr = 1'b0;
        end_rd = 1'b0;
        latch_addr = 1'b0;
        case (style)
            hbp_pkg::HBP_DEMUX: begin
                // Enable high frames; its fall ends the access
                rd_active = pin26 && pin27;
                end_rd = ctl_r.pin26 && !pin26 && ctl_r.pin27;
                end_wr = ctl_r.pin26 && !pin26 && !ctl_r.pin27;
            end
            hbp_pkg::HBP_MUX_SPLIT: begin
                // Active-low strobes; access ends on release
                rd_active = !pin26;
                end_rd = !ctl_r.pin26 && pin26;
                end_wr = !ctl_r.pin27 && pin27;
                latch_addr = ctl_r.pin3 && !addr_hold_strobe;
            end
            hbp_pkg::HBP_MUX_XSTB: begin
                // Read/write high taken as read
                rd_active = pin26 && pin27;
                end_rd = ctl_r.pin26 && !pin26 && ctl_r.pin27;
                end_wr = ctl_r.pin26 && !pin26 && !ctl_r.pin27;
                latch_addr = ctl_r.pin3 && !addr_hold_strobe;
            end
            default: begin
                rd_active = 1'b0;
            end
        endcase
    end

    // DMA needs no select; straps must allow it
    assign dma_cycle = bus_mux_select && (dma_ack_tx || dma_ack_rx);

    // ****************************************************
    // Buffers
    // ****************************************************
    hbp_pkg::hbp_entry_s txf_in, rxf_out;
    logic txf_push, txf_ready, rxf_valid, rxf_pop;
    logic rxf_ready, rxf_push;
    logic [3:0] tx_frames_r, tx_frames_nxt;
    logic [3:0] rx_frames_r, rx_frames_nxt;
    logic tx_room, rx_room;

    // Frame limits on top of byte capacity
    assign tx_room = tx_frames_r < 4'(hbp_pkg::TX_FRAMES_MAX);
    assign rx_room = rx_frames_r < 4'(hbp_pkg::RX_FRAMES_MAX);

    hbp_fifo #(.WIDTH(9), .DEPTH(hbp_pkg::FIFO_DEPTH)) u_txf (
        .clock(clock),
        .resetn(resetn),
        .in_valid(txf_push),
        .in_ready(txf_ready),
        .in_data(txf_in),
        .out_valid(tx_valid),
        .out_ready(tx_ready),
        .out_data(tx_data)
    );

    hbp_fifo #(.WIDTH(9), .DEPTH(hbp_pkg::FIFO_DEPTH)) u_rxf (
        .clock(clock),
        .resetn(resetn),
        .in_valid(rxf_push),
        .in_ready(rxf_ready),
        .in_data(rx_data),
        .out_valid(rxf_valid),
        .out_ready(rxf_pop),
        .out_data(rxf_out)
    );

    // Core stalls once bytes or frame slots run out
    assign rx_ready = rxf_ready && rx_room;
    assign rxf_push = rx_valid && rx_ready;

    // ****************************************************
    // Register state
    // ****************************************************
    logic [5:0] addr_r, addr_nxt;
    logic [7:0] dout_r, dout_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic wr_r, wr_nxt, rd_r, rd_nxt;
    logic int_r, int_nxt;
    logic reqx_r, reqx_nxt, reqr_r, reqr_nxt;
    logic cpu_sel;
    logic [5:0] eff_addr;
    logic local_hit;
    logic [7:0] status;

    // Separated bus uses live address lines
    assign eff_addr = (style == hbp_pkg::HBP_DEMUX) ? addr_lines : addr_r;
    assign cpu_sel = !ctl_r.cs_n && !dma_cycle;
    assign local_hit = (eff_addr >= hbp_pkg::TX_DATA_ADDR);

    always_comb begin
        status = 8'h00;
        status[hbp_pkg::ST_TX_FULL] = !(txf_ready && tx_room);
        status[hbp_pkg::ST_RX_EMPTY] = !rxf_valid;
        status[hbp_pkg::ST_RX_LAST] = rxf_out.last;
    end

    // Next values for address, write data, core strobes, buffer moves and frame counts
    always_comb begin
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        wr_nxt = 1'b0;
        rd_nxt = 1'b0;
        txf_push = 1'b0;
        txf_in = '{last: 1'b0, data: din_r};
        rxf_pop = 1'b0;
        tx_frames_nxt = tx_frames_r;
        rx_frames_nxt = rx_frames_r;
        // Address taken from shared lines on strobe fall
        if (latch_addr && !cs_n) begin
            addr_nxt = din_r[5:0];
        end
        if (dma_cycle) begin
            // Byte moves on strobe end under acknowledge
            if (end_wr && dma_ack_tx) begin
                txf_push = txf_ready && tx_room;
            end
            if (end_rd && dma_ack_rx) begin
                rxf_pop = rxf_valid;
            end
        end else if (cpu_sel && end_wr) begin
            wdata_nxt = din_r;
            if (eff_addr == hbp_pkg::TX_DATA_ADDR ||
                eff_addr == hbp_pkg::TX_EOF_ADDR) begin
                // Writes past capacity are dropped
                txf_push = txf_ready && tx_room;
                txf_in.last = (eff_addr == hbp_pkg::TX_EOF_ADDR);
            end else if (!local_hit) begin
                wr_nxt = 1'b1;
            end
        end else if (cpu_sel && end_rd) begin
            if (eff_addr == hbp_pkg::RX_DATA_ADDR) begin
                rxf_pop = rxf_valid;
            end else if (!local_hit) begin
                rd_nxt = 1'b1;
            end
        end
        // Frame counts follow end markers
        if (txf_push && txf_in.last) begin
            tx_frames_nxt = tx_frames_nxt + 4'h1;
        end
        if (tx_valid && tx_ready && tx_data.last) begin
            tx_frames_nxt = tx_frames_nxt - 4'h1;
        end
        if (rxf_push && rx_data.last) begin
            rx_frames_nxt = rx_frames_nxt + 4'h1;
        end
        if (rxf_pop && rxf_out.last) begin
            rx_frames_nxt = rx_frames_nxt - 4'h1;
        end
    end

    // Read data path and pin drivers
    always_comb begin
        oe_nxt = 1'b0;
        dout_nxt = dout_r;
        if (rd_active && bus_mux_select && dma_ack_rx) begin
            oe_nxt = 1'b1;
            dout_nxt = rxf_out.data;
        end else if (rd_active && !cs_n && !dma_cycle) begin
            oe_nxt = 1'b1;
            case (eff_addr)
                hbp_pkg::RX_DATA_ADDR: dout_nxt = rxf_out.data;
                hbp_pkg::STATUS_ADDR: dout_nxt = status;
                default: dout_nxt = core_rdata;
            endcase
        end
        // Pulled low only; line released otherwise
        int_nxt = core_irq;
        // Requests exist only in multiplexed mode
        reqx_nxt = bus_mux_select && txf_ready && tx_room
                   && !(dma_ack_tx && end_wr);
        reqr_nxt = bus_mux_select && rxf_valid
                   && !(dma_ack_rx && end_rd);
    end

    // ****************************************************
    // Registers
    // ****************************************************
    always_ff @(posedge clock) begin
        if (!resetn) begin
            ctl_r <= '{cs_n: 1'b1, pin27: 1'b1, pin26: 1'b1, pin3: 1'b0};
            din_r <= 8'h00;
            addr_r <= 6'h00;
            dout_r <= 8'h00;
            oe_r <= 1'b0;
            wdata_r <= 8'h00;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            int_r <= 1'b0;
            reqx_r <= 1'b0;
            reqr_r <= 1'b0;
            tx_frames_r <= 4'h0;
            rx_frames_r <= 4'h0;
        end else begin
            ctl_r <= ctl;
            din_r <= data_lines_in;
            addr_r <= addr_nxt;
            dout_r <= dout_nxt;
            oe_r <= oe_nxt;
            wdata_r <= wdata_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            int_r <= int_nxt;
            reqx_r <= reqx_nxt;
            reqr_r <= reqr_nxt;
            tx_frames_r <= tx_frames_nxt;
            rx_frames_r <= rx_frames_nxt;
        end
    end

    // Open drain: level is always low, enable pulls
    assign int_out = 1'b0;
    assign int_oe = int_r;
    assign data_lines_out = dout_r;
    assign data_lines_oe = oe_r;
    assign dma_req_tx = reqx_r;
    assign dma_req_rx = reqr_r;
    assign core_addr = addr_r;
    assign core_wdata = wdata_r;
    assign core_wr = wr_r;
    assign core_rd = rd_r;

endmodule

`default_nettype wire

// ===== hbp_sva.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Host port checker
// ********
module hbp_sva (
    input wire logic clock,
    input wire logic resetn,
    input wire logic bus_mux_select,
    input wire logic split_strobes,
    input wire logic cs_n,
    input wire logic pin27,
    input wire logic pin26,
    input wire logic dma_ack_rx,
    input wire logic data_lines_oe,
    input wire logic int_out,
    input wire logic int_oe,
    input wire logic core_irq,
    input wire logic dma_req_tx,
    input wire logic dma_req_rx,
    input wire logic core_wr,
    input wire logic core_rd,
    input wire logic [5:0] core_addr
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    // Open drain: never driven high
    chk_int_low: assert property (int_out == 1'b0)
        else $error("interrupt pin driven high");
    chk_int_follow: assert property (
        $past(resetn) |-> int_oe == $past(core_irq))
        else $error("interrupt request does not follow core");
    // No handshakes on the separated bus
    chk_dma_sep: assert property (
        !bus_mux_select && !$past(bus_mux_select)
        |-> !dma_req_tx && !dma_req_rx) else $error("dma request off mux");
    // Lines driven only for a selected or acknowledged read
    chk_oe_select: assert property (
        data_lines_oe |-> !$past(cs_n) || $past(dma_ack_rx))
        else $error("lines driven while idle");
    chk_oe_read: assert property (
        !bus_mux_select && data_lines_oe |-> $past(pin27))
        else $error("lines driven in a write");
    chk_wr_select: assert property (
        core_wr |-> !$past(cs_n, 2)) else $error("write while deselected");
    // Enable already low, direction was write
    chk_wr_sep: assert property (
        !bus_mux_select && core_wr |-> !$past(pin26) && !$past(pin27))
        else $error("separated write without enable fall");
    chk_xstb_dir: assert property (
        bus_mux_select && !split_strobes && core_wr |-> !$past(pin27))
        else $error("strobe style write with read level");
    // Strobe levels last two cycles, so pulses cannot merge
    chk_pulse_one: assert property (
        core_wr || core_rd |=> !core_wr && !core_rd)
        else $error("core pulse longer than one cycle");
    // Local buffer addresses never reach the core on a multiplexed write
    chk_mux_addr: assert property (
        bus_mux_select && core_wr |-> core_addr < 6'h3c)
        else $error("local address passed to core");
endmodule

bind hbp_port hbp_sva u_chk (
    .clock(clock), .resetn(resetn), .bus_mux_select(bus_mux_select),
    .split_strobes(split_strobes), .cs_n(cs_n), .pin27(pin27),
    .pin26(pin26),
    .dma_ack_rx(dma_ack_rx), .data_lines_oe(data_lines_oe),
    .int_out(int_out), .int_oe(int_oe), .core_irq(core_irq),
    .dma_req_tx(dma_req_tx), .dma_req_rx(dma_req_rx),
    .core_wr(core_wr), .core_rd(core_rd), .core_addr(core_addr)
);

`default_nettype wire

// ===== hbp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ********
// Processor and DMA engine
// ********
module hbp_host_model (
    input wire logic clock,
    input wire logic [7:0] bus_wire,
    output logic cs_n,
    output logic [5:0] addr_lines,
    output logic [7:0] host_d,
    output logic host_oe,
    output logic pin27,
    output logic pin26,
    output logic addr_hold_strobe,
    output logic dma_ack_tx,
    output logic dma_ack_rx
);
    // Idle: deselected, lines released
    initial begin
        cs_n = 1'b1;
        addr_lines = 6'h00;
        host_d = 8'h00;
        host_oe = 1'b0;
        pin27 = 1'b1;
        pin26 = 1'b0;
        addr_hold_strobe = 1'b0;
        dma_ack_tx = 1'b0;
        dma_ack_rx = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Rest levels; split strobes idle high
    task automatic park(input logic split);
        @(posedge clock);
        pin26 <= split;
        pin27 <= 1'b1;
    endtask

    // One access; every level held two cycles at least
    task automatic xfer(input logic mux, input logic split,
            input logic sel, input logic ack, input logic rd,
            input logic [5:0] a, input logic [7:0] wd,
            output logic [7:0] rv);
        step(1);
        // Select spans the address phase; the latch is gated by it
        cs_n <= ~sel;
        if (mux) begin
            host_oe <= 1'b1;
            host_d <= {2'b00, a};
            addr_hold_strobe <= mux;
            step(2);
            addr_hold_strobe <= 1'b0;
            step(2);
        end
        dma_ack_rx <= ack & rd;
        dma_ack_tx <= ack & ~rd;
        addr_lines <= a;
        host_oe <= ~rd;
        host_d <= wd;
        pin27 <= rd;
        pin26 <= split ? ~rd : 1'b1;
        step(4);
        // Read data has stood since the cycle after the strobe went active
        rv = bus_wire;
        pin27 <= split | rd;
        pin26 <= split;
        step(2);
        cs_n <= 1'b1;
        dma_ack_rx <= 1'b0;
        dma_ack_tx <= 1'b0;
        host_oe <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ********
    // Signals
    // ********
    logic clock = 1'b0;
    logic resetn;
    logic bus_mux_select;
    logic split_strobes;
    logic core_irq;
    logic [7:0] core_rdata;
    logic tx_ready; // Sink stalls until the drain
    logic rx_valid;
    hbp_pkg::hbp_entry_s rx_data;
    logic [7:0] last_v = 8'h00;
    logic cs_n, pin27, pin26, addr_hold_strobe, host_oe, irq_line_n;
    logic [5:0] addr_lines, core_addr;
    logic [7:0] host_d, data_lines_out, bus_wire, core_wdata;
    logic data_lines_oe, int_out, int_oe, core_wr, core_rd;
    logic dma_req_tx, dma_ack_tx, dma_req_rx, dma_ack_rx;
    logic tx_valid, rx_ready;
    hbp_pkg::hbp_entry_s tx_data;
    logic [31:0] seed = 32'h0000002a;
    logic [14:0] wnote;
    logic [14:0] wr_q[$]; // Check-address flag, address, data
    logic [8:0] tx_q[$]; // End marker, byte
    logic [8:0] tnote;
    int rd_seen = 0; // Core read pulses seen
    int error_cnt = 0;
    int total_checks = 0;

    initial begin
        forever #5 clock = ~clock;
    end

    // No pull on the lines: released lines show the inverse
    assign bus_wire = data_lines_oe === 1'b1 ? data_lines_out :
        host_oe ? host_d : ~last_v;
    assign irq_line_n = int_oe === 1'b1 ? int_out : 1'b1;
    always @(posedge clock) last_v <= bus_wire;

    hbp_port u_dut (
        .clock(clock), .resetn(resetn), .bus_mux_select(bus_mux_select),
        .split_strobes(split_strobes), .cs_n(cs_n),
        .addr_lines(addr_lines),
        .data_lines_in(bus_wire), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe), .pin27(pin27), .pin26(pin26),
        .addr_hold_strobe(addr_hold_strobe), .int_out(int_out),
        .int_oe(int_oe), .dma_req_tx(dma_req_tx), .dma_ack_tx(dma_ack_tx),
        .dma_req_rx(dma_req_rx), .dma_ack_rx(dma_ack_rx),
        .core_irq(core_irq), .core_addr(core_addr),
        .core_wdata(core_wdata), .core_wr(core_wr), .core_rd(core_rd),
        .core_rdata(core_rdata), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data)
    );

    hbp_host_model u_host (
        .clock(clock), .bus_wire(bus_wire), .cs_n(cs_n),
        .addr_lines(addr_lines), .host_d(host_d), .host_oe(host_oe),
        .pin27(pin27), .pin26(pin26), .addr_hold_strobe(addr_hold_strobe),
        .dma_ack_tx(dma_ack_tx), .dma_ack_rx(dma_ack_rx)
    );

    // ********
    // Helpers
    // ********
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string what, input logic [7:0] e,
            input logic [7:0] s);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("TB: errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Strobes parked on the same edge as the straps; select is high, so the change is never seen as an access
    task automatic strap(input logic mux, input logic split);
        u_host.park(split);
        bus_mux_select <= mux;
        split_strobes <= split;
        u_host.step(3);
    endtask

    // Monitor: core accesses and bytes leaving the buffer
    always @(posedge clock) begin
        if (core_rd === 1'b1) rd_seen++;
        if (core_wr === 1'b1) begin
            if (wr_q.size() == 0)
                chk("stray core write", 8'h00, 8'h01);
            else begin
                wnote = wr_q.pop_front();
                chk("core wdata", wnote[7:0], core_wdata);
                if (wnote[14]) chk("core addr", {2'b00, wnote[13:8]},
                    {2'b00, core_addr});
            end
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            if (tx_q.size() == 0)
                chk("stray tx byte", 8'h00, 8'h01);
            else begin
                tnote = tx_q.pop_front();
                chk("tx byte", tnote[7:0], tx_data.data);
                chk("tx last", {7'h00, tnote[8]},
                    {7'h00, tx_data.last});
            end
        end
    end

    // ********
    // Scenarios
    // ********
    initial begin
        logic mux, split;
        logic [31:0] r;
        logic [7:0] rv;
        logic [5:0] a;
        resetn <= 1'b0;
        bus_mux_select <= 1'b0;
        split_strobes <= 1'b0;
        core_irq <= 1'b0;
        core_rdata <= 8'h00;
        tx_ready <= 1'b0;
        rx_valid <= 1'b0;
        rx_data <= '0;
        u_host.step(5);
        resetn <= 1'b1;
        // Each style: write, deselected write, read
        for (int s = 0; s < 3; s++) begin
            mux = (s != 0);
            split = (s == 1);
            strap(mux, split);
            r = rnd();
            a = 6'h05 + s[5:0];
            wr_q.push_back({mux, a, r[7:0]});
            u_host.xfer(mux, split, 1'b1, 1'b0, 1'b0, a, r[7:0],
                rv);
            u_host.xfer(mux, split, 1'b0, 1'b0, 1'b0, a, r[15:8],
                rv);
            core_rdata <= r[23:16];
            u_host.xfer(mux, split, 1'b1, 1'b0, 1'b1, a, 8'h00, rv);
            chk("read data", r[23:16], rv);
            chk("tx dma req", {7'h00, mux},
                {7'h00, dma_req_tx});
        end
        // Random level first, then its inverse
        r = rnd();
        core_irq <= r[0];
        u_host.step(3);
        chk("irq line", {7'h00, ~r[0]}, {7'h00, irq_line_n});
        core_irq <= ~r[0];
        u_host.step(3);
        chk("irq line", {7'h00, r[0]}, {7'h00, irq_line_n});
        // Fill: one local end-of-frame push, the rest by handshake
        strap(1'b1, 1'b1);
        r = rnd();
        tx_q.push_back({1'b1, r[7:0]});
        u_host.xfer(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, hbp_pkg::TX_EOF_ADDR,
            r[7:0], rv);
        for (int i = 1; i < hbp_pkg::FIFO_DEPTH; i++) begin
            r = rnd();
            tx_q.push_back({1'b0, r[7:0]});
            u_host.xfer(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 6'h00, r[7:0],
                rv);
        end
        u_host.step(2);
        chk("tx req full", 8'h00, {7'h00, dma_req_tx});
        // Drain with random stalls from the sink
        for (int i = 0; i < 1000 && tx_q.size() > 0; i++) begin
            r = rnd();
            tx_ready <= r[0];
            u_host.step(1);
        end
        tx_ready <= 1'b0;
        r = rnd();
        rx_data <= {1'b1, r[7:0]};
        rx_valid <= 1'b1;
        u_host.step(1);
        for (int i = 0; i < 20 && rx_ready !== 1'b1; i++) u_host.step(1);
        rx_valid <= 1'b0;
        u_host.step(3);
        chk("rx req", 8'h01, {7'h00, dma_req_rx});
        u_host.xfer(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 6'h00, 8'h00, rv);
        chk("rx dma byte", r[7:0], rv);
        u_host.step(2);
        chk("rx req empty", 8'h00, {7'h00, dma_req_rx});
        chk("writes left", 8'h00, 8'(wr_q.size()));
        chk("tx left", 8'h00, 8'(tx_q.size()));
        // One selected read per style; none deselected or by handshake
        chk("core reads", 8'h03, 8'(rd_seen));
        tally_and_finish();
    end

    // Whole run is near 1000 cycles; this cuts a hang
    initial begin
        u_host.step(20000);
        error_cnt++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
